// *** hdl/glh_pkg.sv ***
package glh_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // operating modes handled by this block
    localparam logic [3:0] MODE_GW_INOUT = 4'h4;
    localparam logic [3:0] MODE_GW_HOTLINE = 4'h5;
    localparam logic [3:0] MODE_GW_INOUT_DTR = 4'h6;
    localparam logic [3:0] MODE_GW_HOTLINE_DTR = 4'h7;
    localparam logic [3:0] MODE_HOST_ACCESS = 4'h8;
    localparam logic [3:0] MODE_HOST_HOTLINE = 4'h9;
    localparam logic [3:0] MODE_HOST_LAST = 4'hB;

    ////////////////////////////////////////////////////////////////////////////
    // timing: one timer tick is one millisecond
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_NS = 1_000_000;
    localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned MS_NS = 1_000_000;
    localparam int unsigned DISC_DROP_MS = 200;
    localparam int unsigned OUT_DCD_WAIT_MS = 35_000;
    localparam int unsigned HOST_REL_MS = 100;
    localparam int unsigned MSB_DTR_OFF_MS = 5_000;
    localparam int unsigned RI_ON_MS = 2_000;
    localparam int unsigned RI_OFF_MS = 4_000;
    localparam int unsigned TMR_W = 16;
    localparam logic [TMR_W-1:0] DISC_DROP_TICKS = TMR_W'(DISC_DROP_MS * MS_NS / TICK_NS);
    localparam logic [TMR_W-1:0] OUT_WAIT_TICKS = TMR_W'(OUT_DCD_WAIT_MS * MS_NS / TICK_NS);
    localparam logic [TMR_W-1:0] HOST_REL_TICKS = TMR_W'(HOST_REL_MS * MS_NS / TICK_NS);
    localparam logic [TMR_W-1:0] MSB_TICKS = TMR_W'(MSB_DTR_OFF_MS * MS_NS / TICK_NS);
    localparam logic [TMR_W-1:0] RI_ON_TICKS = TMR_W'(RI_ON_MS * MS_NS / TICK_NS);
    localparam logic [TMR_W-1:0] RI_OFF_TICKS = TMR_W'(RI_OFF_MS * MS_NS / TICK_NS);
    localparam int unsigned LEAD_W = 3;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OUT_WAIT,
        ST_HL_CALL,
        ST_CONN,
        ST_DISC,
        ST_RING,
        ST_H_ANS,
        ST_H_CONN
    } glh_state_e;

    // leads received from the far equipment, after synchronising
    typedef struct packed {
        logic dcd;
        logic dsr;
        logic dtr;
    } glh_lead_s;

    // leads this card drives
    typedef struct packed {
        logic dtr;
        logic cts;
        logic dsr;
        logic dcd;
        logic ri;
    } glh_drive_s;

    typedef struct packed {
        glh_state_e st;
        logic [3:0] mode;
        logic [TMR_W-1:0] timer;
        logic [TMR_W-1:0] dtr_off;
        glh_lead_s prev;
        glh_drive_s drive;
        logic answer;
        logic release_call;
        logic hotline;
        logic busy;
        logic prompts;
        logic autobaud;
        logic msb;
        logic dial_ok;
    } glh_regs_s;

endpackage : glh_pkg

// *** hdl/glh_sync2.sv ***
`timescale 1ns/1ps
module glh_sync2 #(
    parameter int unsigned WIDTH = 3
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : glh_sync2

// *** hdl/glh_tick.sv ***
`timescale 1ns/1ps
module glh_tick #(
    parameter int unsigned PERIOD = 100_000
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    output logic tick_out
);

    localparam int unsigned CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] cnt_ff;
    logic tick_ff;

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_ff <= (cnt_ff == LAST);
            cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
        end
    end

    assign tick_out = tick_ff;

endmodule : glh_tick

// *** hdl/glh_lead_ctrl.sv ***
// What this block does
// - modes 4-7: act as terminal side, drive DTR, watch DSR/DCD, no RI input
// - gateway modes: prompts only for inbound calls, never while DCD is off
// - modes 4,5: DTR off when idle, on while a call is handled
// - modes 6,7: DTR on always, dropped 0.2 s at disconnect
// - outbound gateway: answer the data module's call, raise DTR, pass data
// - mode 4 outbound: no DCD within 35 s drops DTR and the call
// - gateway: established call is released on DSR or DCD falling
// - inbound, modes 4,6: rising DCD raises DTR, busies unit, arms autobaud
// - mode 4 inbound: DTR off until DCD on, then DTR on and busy
// - mode 5: DCD on starts hotline, retried while DCD stays on
// - host modes: drive CTS/DSR/DCD/RI, CTS/DSR/DCD off when idle
// - host modes: no prompts, menus or echo towards the host
// - host incoming call: RI 2 s on, 4 s off until DTR, then answer
// - host incoming call with DTR already on: answer at once, no RI
// - after protocol exchange succeeds, CTS/DSR/DCD on until release
// - modes 8,9: DTR off over 100 ms releases an established call
// - with busy-on-DTR-drop set, DTR off over 5 s makes set busy
// - mode 8: dialing commands accepted blind, without echo
// - mode 9: DTR rising places a hotline call to the target number
`timescale 1ns/1ps
module glh_lead_ctrl #(
    parameter int unsigned TICK_CYCLES = glh_pkg::TICK_CYCLES
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] mode_sel_in,
    input wire logic busy_on_dtr_drop_in,
    input wire logic dcd_in,
    input wire logic dsr_in,
    input wire logic dtr_in,
    input wire logic call_offer_in,
    input wire logic outbound_connect_in,
    input wire logic proto_ok_in,
    input wire logic call_fail_in,
    input wire logic call_released_in,
    output logic dtr_out,
    output logic cts_out,
    output logic dsr_out,
    output logic dcd_out,
    output logic ri_out,
    output logic answer_out,
    output logic release_out,
    output logic hotline_req_out,
    output logic unit_busy_out,
    output logic prompts_en_out,
    output logic autobaud_arm_out,
    output logic make_set_busy_out,
    output logic dial_accept_out
);

    ////////////////////////////////////////////////////////////////////////////
    // lead synchronisers and timer tick

    glh_pkg::glh_lead_s ld;
    logic tick;

    glh_sync2 #(
        .WIDTH(glh_pkg::LEAD_W)
    ) u_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in({dcd_in, dsr_in, dtr_in}),
        .sync_out(ld)
    );

    glh_tick #(
        .PERIOD(TICK_CYCLES)
    ) u_tick (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .tick_out(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // mode decode from the latched mode

    glh_pkg::glh_regs_s r_ff;
    glh_pkg::glh_regs_s nxt_r;

    logic is_gw;
    logic is_host;
    logic gw_hotline;
    logic gw_dtr_hold;

    assign is_gw = (r_ff.mode >= glh_pkg::MODE_GW_INOUT) &&
                   (r_ff.mode <= glh_pkg::MODE_GW_HOTLINE_DTR);
    assign is_host = (r_ff.mode >= glh_pkg::MODE_HOST_ACCESS) &&
                     (r_ff.mode <= glh_pkg::MODE_HOST_LAST);
    assign gw_hotline = (r_ff.mode == glh_pkg::MODE_GW_HOTLINE) ||
                        (r_ff.mode == glh_pkg::MODE_GW_HOTLINE_DTR);
    assign gw_dtr_hold = (r_ff.mode == glh_pkg::MODE_GW_INOUT_DTR) ||
                         (r_ff.mode == glh_pkg::MODE_GW_HOTLINE_DTR);

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb
    begin
        logic dcd_rise;
        logic dcd_fall;
        logic dsr_fall;
        logic dtr_rise;
        logic go_rel;
        dcd_rise = ld.dcd & ~r_ff.prev.dcd;
        dcd_fall = ~ld.dcd & r_ff.prev.dcd;
        dsr_fall = ~ld.dsr & r_ff.prev.dsr;
        dtr_rise = ld.dtr & ~r_ff.prev.dtr;
        go_rel = 1'b0;

        nxt_r = r_ff;
        nxt_r.prev = ld;
        nxt_r.answer = 1'b0;
        nxt_r.release_call = 1'b0;
        nxt_r.hotline = 1'b0;
        // saturating counters so a long wait never wraps into a short one
        if (tick && (r_ff.timer != '1))
        begin
            nxt_r.timer = r_ff.timer + 1'b1;
        end
        if (ld.dtr)
        begin
            nxt_r.dtr_off = '0;
        end
        else if (tick && (r_ff.dtr_off != '1))
        begin
            nxt_r.dtr_off = r_ff.dtr_off + 1'b1;
        end

        unique case (r_ff.st)
            glh_pkg::ST_IDLE:
            begin
                nxt_r.drive = '0;
                nxt_r.drive.dtr = is_gw && gw_dtr_hold;
                if (is_gw && dcd_rise)
                begin
                    nxt_r.drive.dtr = 1'b1;
                    nxt_r.busy = 1'b1;
                    nxt_r.timer = '0;
                    if (gw_hotline)
                    begin
                        nxt_r.hotline = 1'b1;
                        nxt_r.st = glh_pkg::ST_HL_CALL;
                    end
                    else
                    begin
                        nxt_r.prompts = 1'b1;
                        nxt_r.autobaud = 1'b1;
                        nxt_r.st = glh_pkg::ST_CONN;
                    end
                end
                else if (is_gw && outbound_connect_in && !gw_hotline)
                begin
                    nxt_r.answer = 1'b1;
                    nxt_r.drive.dtr = 1'b1;
                    nxt_r.busy = 1'b1;
                    nxt_r.prompts = 1'b0;
                    nxt_r.timer = '0;
                    nxt_r.st = glh_pkg::ST_OUT_WAIT;
                end
                else if (is_host && call_offer_in)
                begin
                    nxt_r.busy = 1'b1;
                    nxt_r.timer = '0;
                    if (ld.dtr)
                    begin
                        nxt_r.answer = 1'b1;
                        nxt_r.st = glh_pkg::ST_H_ANS;
                    end
                    else
                    begin
                        nxt_r.drive.ri = 1'b1;
                        nxt_r.st = glh_pkg::ST_RING;
                    end
                end
                else if (is_host && (r_ff.mode == glh_pkg::MODE_HOST_HOTLINE) && dtr_rise)
                begin
                    nxt_r.hotline = 1'b1;
                    nxt_r.busy = 1'b1;
                    nxt_r.st = glh_pkg::ST_H_ANS;
                end
            end

            glh_pkg::ST_HL_CALL:
            begin
                if (!ld.dcd)
                begin
                    nxt_r.release_call = 1'b1;
                    go_rel = 1'b1;
                end
                else if (proto_ok_in)
                begin
                    nxt_r.prompts = 1'b1;
                    nxt_r.st = glh_pkg::ST_CONN;
                end
                else if (call_fail_in)
                begin
                    nxt_r.hotline = 1'b1;
                end
            end

            glh_pkg::ST_OUT_WAIT:
            begin
                if (call_released_in)
                begin
                    go_rel = 1'b1;
                end
                else if (ld.dcd)
                begin
                    nxt_r.st = glh_pkg::ST_CONN;
                end
                else if (!gw_dtr_hold && (r_ff.timer >= glh_pkg::OUT_WAIT_TICKS))
                begin
                    nxt_r.release_call = 1'b1;
                    go_rel = 1'b1;
                end
            end

            glh_pkg::ST_CONN:
            begin
                // a gateway dropping either lead ends the call
                if (dcd_fall || dsr_fall)
                begin
                    nxt_r.release_call = 1'b1;
                    go_rel = 1'b1;
                end
                else if (call_released_in)
                begin
                    go_rel = 1'b1;
                end
            end

            glh_pkg::ST_DISC:
            begin
                if (!(is_gw && gw_dtr_hold))
                begin
                    nxt_r.st = glh_pkg::ST_IDLE;
                end
                else if (r_ff.timer > glh_pkg::DISC_DROP_TICKS)
                begin
                    nxt_r.drive.dtr = 1'b1;
                    nxt_r.st = glh_pkg::ST_IDLE;
                end
            end

            glh_pkg::ST_RING:
            begin
                if (ld.dtr)
                begin
                    nxt_r.drive.ri = 1'b0;
                    nxt_r.answer = 1'b1;
                    nxt_r.st = glh_pkg::ST_H_ANS;
                end
                else if (call_released_in)
                begin
                    go_rel = 1'b1;
                end
                else if (r_ff.drive.ri && (r_ff.timer >= glh_pkg::RI_ON_TICKS))
                begin
                    nxt_r.drive.ri = 1'b0;
                    nxt_r.timer = '0;
                end
                else if (!r_ff.drive.ri && (r_ff.timer >= glh_pkg::RI_OFF_TICKS))
                begin
                    nxt_r.drive.ri = 1'b1;
                    nxt_r.timer = '0;
                end
            end

            glh_pkg::ST_H_ANS:
            begin
                if (call_released_in)
                begin
                    go_rel = 1'b1;
                end
                else if (proto_ok_in)
                begin
                    nxt_r.drive.cts = 1'b1;
                    nxt_r.drive.dsr = 1'b1;
                    nxt_r.drive.dcd = 1'b1;
                    nxt_r.st = glh_pkg::ST_H_CONN;
                end
            end

            glh_pkg::ST_H_CONN:
            begin
                if (r_ff.dtr_off > glh_pkg::HOST_REL_TICKS)
                begin
                    nxt_r.release_call = 1'b1;
                    go_rel = 1'b1;
                end
                else if (call_released_in)
                begin
                    go_rel = 1'b1;
                end
            end
        endcase

        if (go_rel)
        begin
            // every lead this card drives goes off; hold modes restore DTR later
            nxt_r.drive = '0;
            nxt_r.busy = 1'b0;
            nxt_r.prompts = 1'b0;
            nxt_r.autobaud = 1'b0;
            nxt_r.timer = '0;
            nxt_r.st = glh_pkg::ST_DISC;
        end

        // host side never prompts or echoes
        if (!is_gw || !ld.dcd)
        begin
            nxt_r.prompts = 1'b0;
        end
        if (!is_host || ld.dtr)
        begin
            nxt_r.msb = 1'b0;
        end
        else if (busy_on_dtr_drop_in && (r_ff.dtr_off > glh_pkg::MSB_TICKS))
        begin
            nxt_r.msb = 1'b1;
        end
        nxt_r.dial_ok = (r_ff.mode == glh_pkg::MODE_HOST_ACCESS) &&
                        (nxt_r.st == glh_pkg::ST_IDLE);

        if (sys_rst_in)
        begin
            nxt_r = '0;
            nxt_r.st = glh_pkg::ST_IDLE;
            nxt_r.mode = mode_sel_in;
        end
    end

    always_ff @(posedge clk_in)
    begin
        r_ff <= nxt_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register

    assign dtr_out = r_ff.drive.dtr;
    assign cts_out = r_ff.drive.cts;
    assign dsr_out = r_ff.drive.dsr;
    assign dcd_out = r_ff.drive.dcd;
    assign ri_out = r_ff.drive.ri;
    assign answer_out = r_ff.answer;
    assign release_out = r_ff.release_call;
    assign hotline_req_out = r_ff.hotline;
    assign unit_busy_out = r_ff.busy;
    assign prompts_en_out = r_ff.prompts;
    assign autobaud_arm_out = r_ff.autobaud;
    assign make_set_busy_out = r_ff.msb;
    assign dial_accept_out = r_ff.dial_ok;

endmodule : glh_lead_ctrl

// *** dv/glh_lead_ctrl_assertions.sv ***
`timescale 1ns/1ps
module glh_lead_ctrl_assertions #(
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] mode_sel_in,
    input wire logic busy_on_dtr_drop_in,
    input wire logic dcd_in,
    input wire logic dtr_in,
    input wire logic call_offer_in,
    input wire logic call_fail_in,
    input wire logic dtr_out,
    input wire logic cts_out,
    input wire logic dsr_out,
    input wire logic dcd_out,
    input wire logic ri_out,
    input wire logic answer_out,
    input wire logic release_out,
    input wire logic hotline_req_out,
    input wire logic unit_busy_out,
    input wire logic prompts_en_out,
    input wire logic autobaud_arm_out,
    input wire logic make_set_busy_out
);
    localparam int TC = int'(TICK_CYCLES);
    localparam int RI_LO = (int'(glh_pkg::RI_ON_TICKS) - 1) * TC;
    localparam int RI_HI = (int'(glh_pkg::RI_ON_TICKS) + 1) * TC + 2;
    localparam int DR_LO = (int'(glh_pkg::DISC_DROP_TICKS) - 1) * TC;
    localparam int DR_HI = (int'(glh_pkg::DISC_DROP_TICKS) + 1) * TC + 2;
    localparam int MSB_LO = int'(glh_pkg::MSB_TICKS) * TC;
    logic [3:0] mode_ff;
    int ri_on_ff;
    int dtr_lo_ff;
    int raw_lo_ff;
    logic gw;
    logic host;
    assign gw = (mode_ff >= 4'h4) && (mode_ff <= 4'h7);
    assign host = (mode_ff >= 4'h8) && (mode_ff <= 4'hB);

    ////////////////////////////////////////////////////////////////////////////
    // durations measured at the pins, so tick phase slack is allowed for
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            mode_ff <= mode_sel_in;
            ri_on_ff <= 0;
            dtr_lo_ff <= 0;
            raw_lo_ff <= 0;
        end
        else
        begin
            ri_on_ff <= ri_out ? ri_on_ff + 1 : 0;
            dtr_lo_ff <= dtr_out ? 0 : dtr_lo_ff + 1;
            raw_lo_ff <= dtr_in ? 0 : raw_lo_ff + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_dcd_up;
        $rose(dcd_in) ##1 dcd_in [*3];
    endsequence
    sequence s_dcd_held;
        dcd_in [*4];
    endsequence
    sequence s_dtr_held;
        dtr_in [*4];
    endsequence

    a_gw_roles: assert property (
        gw |-> !(ri_out || cts_out || dsr_out || dcd_out)) else $error("host lead in gateway mode");
    a_prompt_dcd: assert property (
        prompts_en_out |-> (dcd_in || $past(dcd_in) || $past(dcd_in, 2) || $past(dcd_in, 3)
            || $past(dcd_in, 4))) else $error("prompts while carrier off");
    a_host_quiet: assert property (
        host |-> !prompts_en_out) else $error("prompts in host mode");
    a_host_leads: assert property (
        host |-> (cts_out == dsr_out) && (dsr_out == dcd_out)) else $error("host leads split");
    a_dtr_busy: assert property (
        (mode_ff == 4'h4 || mode_ff == 4'h5) && dtr_out |-> unit_busy_out)
        else $error("dtr on while idle");
    a_ri_cadence: assert property (
        $fell(ri_out) && !answer_out |-> ri_on_ff >= RI_LO && ri_on_ff <= RI_HI)
        else $error("ring on time wrong");
    a_dtr_drop: assert property (
        gw && mode_ff[1] && $rose(dtr_out) && dtr_lo_ff > 8 |-> dtr_lo_ff >= DR_LO
            && dtr_lo_ff <= DR_HI) else $error("disconnect drop length wrong");
    a_msb_delay: assert property (
        $rose(make_set_busy_out) |-> $past(busy_on_dtr_drop_in) && raw_lo_ff > MSB_LO)
        else $error("make set busy too early");
    a_gw_inbound: assert property (
        (mode_ff == 4'h4 && !unit_busy_out) ##0 s_dcd_up |=> dtr_out && unit_busy_out
            && autobaud_arm_out) else $error("inbound activation missing");
    a_hl_retry: assert property (
        s_dcd_held ##0 (gw && mode_ff[0] && call_fail_in && unit_busy_out && !prompts_en_out)
            |=> hotline_req_out) else $error("hotline not retried");
    a_host_now: assert property (
        s_dtr_held ##0 (host && call_offer_in && !unit_busy_out) |=> answer_out && !ri_out)
        else $error("no immediate answer");
    a_rel_clear: assert property (
        release_out |-> !(cts_out || dsr_out || dcd_out || unit_busy_out))
        else $error("leads left on at release");
endmodule : glh_lead_ctrl_assertions

bind glh_lead_ctrl glh_lead_ctrl_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk_in,
    .sys_rst_in, .mode_sel_in, .busy_on_dtr_drop_in, .dcd_in, .dtr_in, .call_offer_in,
    .call_fail_in, .dtr_out, .cts_out, .dsr_out, .dcd_out, .ri_out, .answer_out, .release_out,
    .hotline_req_out, .unit_busy_out, .prompts_en_out, .autobaud_arm_out, .make_set_busy_out);

// *** dv/glh_far_end.sv ***
`timescale 1ns/1ps
module glh_far_end (
    input wire logic clk_in,
    input wire logic dcd_req_in,
    input wire logic dsr_req_in,
    input wire logic dtr_req_in,
    input wire logic auto_ans_in,
    input wire logic [31:0] ans_dly_in,
    input wire logic ri_in,
    output logic dcd_out,
    output logic dsr_out,
    output logic dtr_out
);
    logic [31:0] ans_cnt_ff = 32'h0;
    logic answered_ff = 1'b0;

    // auto-answer counts from the first ring, so slow hosts span several rings
    always_ff @(posedge clk_in)
    begin
        dcd_out <= dcd_req_in;
        dsr_out <= dsr_req_in;
        if (!auto_ans_in)
        begin
            ans_cnt_ff <= 32'h0;
            answered_ff <= 1'b0;
        end
        else if (ri_in || ans_cnt_ff != 32'h0)
        begin
            ans_cnt_ff <= ans_cnt_ff + 32'h1;
            if (ans_cnt_ff == ans_dly_in)
                answered_ff <= 1'b1;
        end
        dtr_out <= dtr_req_in | answered_ff;
    end
endmodule : glh_far_end

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
    localparam int TC = 4;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [3:0] mode_sel_in;
    logic call_offer_in = 1'b0, outbound_connect_in = 1'b0, proto_ok_in = 1'b0;
    logic call_fail_in = 1'b0, rel_in, busy_on_dtr_drop_in, dcd_req, dsr_req, dtr_req, auto_ans;
    logic [31:0] dly;
    logic dcd_in, dsr_in, dtr_in, dtr_out, cts_out, dsr_out, dcd_out, ri_out, answer_out;
    logic release_out, hotline_req_out, unit_busy_out, prompts_en_out, autobaud_arm_out;
    logic make_set_busy_out, dial_accept_out;
    int bad_count = 0;
    int n_compared = 0;
    byte exp_q[$];

    always #5 clk_in = ~clk_in;

    glh_lead_ctrl #(.TICK_CYCLES(TC)) DUT (.clk_in, .sys_rst_in, .mode_sel_in,
        .busy_on_dtr_drop_in, .dcd_in, .dsr_in, .dtr_in, .call_offer_in, .outbound_connect_in,
        .proto_ok_in, .call_fail_in, .call_released_in(rel_in), .dtr_out, .cts_out, .dsr_out,
        .dcd_out, .ri_out, .answer_out, .release_out, .hotline_req_out, .unit_busy_out,
        .prompts_en_out, .autobaud_arm_out, .make_set_busy_out, .dial_accept_out);
    glh_far_end u_far (.clk_in, .dcd_req_in(dcd_req), .dsr_req_in(dsr_req),
        .dtr_req_in(dtr_req), .auto_ans_in(auto_ans), .ans_dly_in(dly), .ri_in(ri_out),
        .dcd_out(dcd_in), .dsr_out(dsr_in), .dtr_out(dtr_in));

    ////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : cyc

    task automatic chk(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk

    // 1 answer, 2 release, 3 hotline
    task automatic chk_evt(input byte code);
        n_compared++;
        if (exp_q.size() == 0 || exp_q[0] !== code)
        begin
            bad_count++;
            $display("mismatch at %0t: unexpected pulse %0d", $time, code);
        end
        if (exp_q.size() != 0)
            void'(exp_q.pop_front());
    endtask : chk_evt

    task automatic start(input logic [3:0] m);
        {dcd_req, dsr_req, dtr_req, auto_ans, rel_in, busy_on_dtr_drop_in} = 6'h0;
        mode_sel_in = m;
        sys_rst_in = 1'b1;
        cyc(10);
        sys_rst_in = 1'b0;
        cyc(2);
    endtask : start

    // 0 offer, 1 outbound, 2 protocol ok, 3 call fail, 4 switch release
    task automatic pulse(input int k);
        {rel_in, call_fail_in, proto_ok_in, outbound_connect_in, call_offer_in} = 5'(1 << k);
        cyc(1);
        {call_offer_in, outbound_connect_in, proto_ok_in, call_fail_in, rel_in} = 5'h0;
        cyc(1);
    endtask : pulse

    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    always @(posedge clk_in)
    begin
        if (!sys_rst_in)
        begin
            if (answer_out === 1'b1) chk_evt(8'h1);
            if (release_out === 1'b1) chk_evt(8'h2);
            if (hotline_req_out === 1'b1) chk_evt(8'h3);
        end
    end

    initial
    begin
        repeat (60000) @(posedge clk_in);
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(5387));
        start(4'h4);
        chk(dtr_out, 1'b0, "idle dtr");
        dcd_req = 1'b1;
        cyc(8);
        chk(dtr_out, 1'b1, "inbound dtr");
        chk(autobaud_arm_out, 1'b1, "autobaud");
        chk(prompts_en_out, 1'b1, "inbound prompts");
        chk(ri_out, 1'b0, "ri in gateway");
        exp_q.push_back(8'h2);
        dcd_req = 1'b0;
        cyc(8);
        chk(unit_busy_out, 1'b0, "busy after drop");
        exp_q.push_back(8'h1);
        pulse(1);
        cyc(2);
        chk(dtr_out, 1'b1, "outbound dtr");
        chk(prompts_en_out, 1'b0, "outbound prompts");
        {dcd_req, dsr_req} = 2'b11;
        cyc(8);
        exp_q.push_back(8'h2);
        dsr_req = 1'b0;
        cyc(8);
        chk(dtr_out, 1'b0, "dtr after dsr drop");
        dcd_req = 1'b0;
        cyc(8);
        $display("test mode4 done");
        start(4'h6);
        chk(dtr_out, 1'b1, "idle dtr mode6");
        dcd_req = 1'b1;
        cyc(8);
        exp_q.push_back(8'h2);
        dcd_req = 1'b0;
        cyc(150 * TC);
        chk(dtr_out, 1'b0, "disconnect drop");
        cyc(60 * TC);
        chk(dtr_out, 1'b1, "dtr back");
        $display("test mode6 done");
        for (int m = 5; m <= 7; m += 2)
        begin
            start(4'(m));
            exp_q.push_back(8'h3);
            exp_q.push_back(8'h3);
            dcd_req = 1'b1;
            cyc(8);
            chk(dtr_out, 1'b1, "hotline dtr");
            pulse(3);
            cyc(2);
            pulse(2);
            cyc(2);
            chk(prompts_en_out, 1'b1, "hotline prompts");
            exp_q.push_back(8'h2);
            dcd_req = 1'b0;
            cyc(8);
            chk(prompts_en_out, 1'b0, "prompts off");
            $display("test hotline mode %0d done", m);
        end
        start(4'h8);
        chk(dial_accept_out, 1'b1, "blind dial");
        chk(dsr_out, 1'b0, "idle dsr");
        dly = (32'd6200 + ($urandom % 32'd600)) * TC;
        auto_ans = 1'b1;
        exp_q.push_back(8'h1);
        pulse(0);
        chk(ri_out, 1'b1, "ring on");
        cyc(1900 * TC);
        chk(ri_out, 1'b1, "ring still on");
        cyc(200 * TC);
        chk(ri_out, 1'b0, "ring off");
        cyc(3900 * TC);
        chk(ri_out, 1'b1, "second ring");
        chk(make_set_busy_out, 1'b0, "msb off");
        cyc(800 * TC);
        chk(ri_out, 1'b0, "ring stops");
        pulse(2);
        chk(cts_out & dsr_out & dcd_out, 1'b1, "leads on");
        auto_ans = 1'b0;
        cyc(50 * TC);
        dtr_req = 1'b1;
        cyc(10);
        chk(dsr_out, 1'b1, "short drop kept");
        exp_q.push_back(8'h2);
        dtr_req = 1'b0;
        cyc(110 * TC);
        chk(dsr_out, 1'b0, "released");
        chk(make_set_busy_out, 1'b0, "msb early");
        busy_on_dtr_drop_in = 1'b1;
        cyc(4950 * TC);
        chk(make_set_busy_out, 1'b1, "msb");
        dtr_req = 1'b1;
        cyc(8);
        chk(make_set_busy_out, 1'b0, "msb cleared");
        exp_q.push_back(8'h1);
        pulse(0);
        chk(ri_out, 1'b0, "no ring");
        pulse(4);
        chk(dial_accept_out, 1'b1, "redial");
        $display("test mode8 done");
        start(4'h9);
        exp_q.push_back(8'h3);
        dtr_req = 1'b1;
        cyc(8);
        chk(1'(exp_q.size() == 0), 1'b1, "pulses pending");
        $display("test mode9 done");
        final_report();
    end
endmodule : tb
